// ===== rtl/lvss_sequencer.sv
// Low-voltage stop sequencer with power-on request to the regulator IC
//
// Functional notes
// - Drive single power-on request to regulator select
// - Deassert request on entering low-voltage stop
// - Wake: reassert request, start core settle timer
// - After core settle timer, start clock restore
// - Oscillator stable starts exit delay timer
// - Exit delay expiry returns to Run
// - Plain stop skips core timer, 100 us
// - No CPU-off variant on shared regulator
// - CPU-good flag starts CPU settle timer
// - CPU-off exit waits both timers expired
// - Exit delay default 0x20000 in 22 bits
`timescale 1ns/1ns
module lvss_sequencer (
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire lvss_pkg::lvss_req_t regReq,
   output logic [31:0]             regRdata,
   input  wire logic               stopRequest,
   input  wire logic               wakeupEvent,
   input  wire logic               cpuSupplyAboveThreshold,
   output logic                    power_on_request_out,
   output logic                    runMode,
   output logic                    clockRestore,
   output logic                    expiryPulse
);

   // Registers
   logic [3:0]                  ctrl_reg;
   logic [21:0]                 delay_reg;
   logic [21:0]                 cpuSet_reg;
   logic [31:0]                 rdata_reg;
   lvss_pkg::lvss_state_t       state_reg, state_next;
   logic                        cpuOffStop_reg, plainStop_reg;
   logic [21:0]                 coreCnt_reg, exitCnt_reg, cpuCnt_reg, oscCnt_reg;
   logic                        exitDone_reg, cpuDone_reg, cpuGood_reg;
   logic                        pwrOn_reg, expiry_reg;
   logic                        wakeS1_reg, wakeS2_reg, cpuS1_reg, cpuS2_reg;
   logic                        stopS1_reg, stopS2_reg;

   // Decoded control bits
   wire lowVoltSel = ctrl_reg[lvss_pkg::LPSLEEP_POS] & ctrl_reg[lvss_pkg::LVSLEEP_POS];
   wire cpuOffSel  = ctrl_reg[lvss_pkg::CPUOFF_POS] & ~ctrl_reg[lvss_pkg::SHARED_POS];
   wire wrCtrl     = regReq.wr && regReq.addr == lvss_pkg::CTRL_OFS;
   wire wrDelay    = regReq.wr && regReq.addr == lvss_pkg::DELAY_OFS;
   wire wrCpuSet   = regReq.wr && regReq.addr == lvss_pkg::CPUSET_OFS;

   // Timer expiries as one-cycle events
   wire coreExpire = state_reg == lvss_pkg::ST_CORE && coreCnt_reg == 22'h0;
   wire oscExpire  = state_reg == lvss_pkg::ST_CLOCK && oscCnt_reg == 22'h0;
   wire exitExpire = state_reg == lvss_pkg::ST_EXIT && !exitDone_reg
                     && exitCnt_reg == 22'h0;
   wire cpuExpire  = state_reg == lvss_pkg::ST_EXIT && cpuGood_reg && !cpuDone_reg
                     && cpuCnt_reg == 22'h0;
   wire exitOk     = (exitDone_reg | exitExpire)
                     && (!cpuOffStop_reg || cpuDone_reg || cpuExpire);

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         lvss_pkg::ST_RUN:   if (stopS2_reg && ctrl_reg[lvss_pkg::LPSLEEP_POS])
                                state_next = lvss_pkg::ST_STOP;
         lvss_pkg::ST_STOP:  if (wakeS2_reg)
                                state_next = plainStop_reg ? lvss_pkg::ST_CLOCK
                                                           : lvss_pkg::ST_CORE;
         lvss_pkg::ST_CORE:  if (coreExpire) state_next = lvss_pkg::ST_CLOCK;
         lvss_pkg::ST_CLOCK: if (oscExpire) state_next = lvss_pkg::ST_EXIT;
         lvss_pkg::ST_EXIT:  if (exitOk) state_next = lvss_pkg::ST_RUN;
         default:            state_next = lvss_pkg::ST_RUN;
      endcase
   end

   // Input synchronisers
   always_ff @(posedge clk) begin
      wakeS1_reg <= wakeupEvent;
      wakeS2_reg <= wakeS1_reg;
      cpuS1_reg  <= cpuSupplyAboveThreshold;
      cpuS2_reg  <= cpuS1_reg;
      stopS1_reg <= stopRequest;
      stopS2_reg <= stopS1_reg;
   end

   // Software registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg   <= 4'h0;
         delay_reg  <= lvss_pkg::DLY_RESET;
         cpuSet_reg <= lvss_pkg::CPU_SETTLE_RESET;
      end else begin
         if (wrCtrl) ctrl_reg <= regReq.wdata[3:0];
         if (wrDelay) delay_reg <= regReq.wdata[21:0];
         if (wrCpuSet) cpuSet_reg <= regReq.wdata[21:0];
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) rdata_reg <= 32'h0;
      else if (regReq.rd) begin
         case (regReq.addr)
            lvss_pkg::CTRL_OFS:   rdata_reg <= {28'h0, ctrl_reg};
            lvss_pkg::DELAY_OFS:  rdata_reg <= {10'h0, delay_reg};
            lvss_pkg::CPUSET_OFS: rdata_reg <= {10'h0, cpuSet_reg};
            lvss_pkg::STATUS_OFS: rdata_reg <= {25'h0, cpuGood_reg, cpuOffStop_reg,
                                               pwrOn_reg, 1'b0, state_reg};
            default:              rdata_reg <= 32'h0;
         endcase
      end else rdata_reg <= 32'h0;
   end

   // Sequencer state, stop variant and power-on request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg      <= lvss_pkg::ST_RUN;
         pwrOn_reg      <= 1'b1;
         cpuOffStop_reg <= 1'b0;
         plainStop_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == lvss_pkg::ST_RUN && state_next == lvss_pkg::ST_STOP) begin
            plainStop_reg  <= !lowVoltSel;
            cpuOffStop_reg <= lowVoltSel && cpuOffSel;
            pwrOn_reg      <= !lowVoltSel;
         end
         if (state_reg == lvss_pkg::ST_STOP && wakeS2_reg) pwrOn_reg <= 1'b1;
      end
   end

   // Down-counters for all wake timers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         coreCnt_reg  <= 22'h0;
         oscCnt_reg   <= 22'h0;
         exitCnt_reg  <= 22'h0;
         cpuCnt_reg   <= 22'h0;
         exitDone_reg <= 1'b0;
         cpuDone_reg  <= 1'b0;
         cpuGood_reg  <= 1'b0;
         expiry_reg   <= 1'b0;
      end else begin
         expiry_reg <= coreExpire | exitExpire | cpuExpire;
         if (state_reg == lvss_pkg::ST_STOP) begin
            coreCnt_reg  <= 22'(lvss_pkg::CORE_SETTLE_CYC - 1);
            oscCnt_reg   <= 22'(lvss_pkg::OSC_STABLE_CYC - 1);
            exitDone_reg <= 1'b0;
            cpuDone_reg  <= 1'b0;
            cpuGood_reg  <= 1'b0;
         end
         if (state_reg == lvss_pkg::ST_CORE && !coreExpire) coreCnt_reg <= coreCnt_reg - 22'h1;
         if (state_reg == lvss_pkg::ST_CLOCK) begin
            if (!oscExpire) oscCnt_reg <= oscCnt_reg - 22'h1;
            exitCnt_reg <= plainStop_reg
                           ? 22'(lvss_pkg::PLAIN_EXIT_CYC - 1)
                           : delay_reg;
         end
         if (state_reg == lvss_pkg::ST_EXIT) begin
            if (exitExpire) exitDone_reg <= 1'b1;
            else if (!exitDone_reg) exitCnt_reg <= exitCnt_reg - 22'h1;
            if (cpuOffStop_reg && !cpuGood_reg && cpuS2_reg) begin
               cpuGood_reg <= 1'b1;
               cpuCnt_reg  <= cpuSet_reg;
            end
            if (cpuExpire) cpuDone_reg <= 1'b1;
            else if (cpuGood_reg && !cpuDone_reg) cpuCnt_reg <= cpuCnt_reg - 22'h1;
         end
      end
   end

   // Outputs
   assign regRdata             = rdata_reg;
   assign power_on_request_out = pwrOn_reg;
   assign runMode              = state_reg == lvss_pkg::ST_RUN;
   assign clockRestore         = state_reg == lvss_pkg::ST_CLOCK;
   assign expiryPulse          = expiry_reg;

endmodule : lvss_sequencer

// ===== common/lvss_pkg.sv
// Package with constants and types for the low-voltage stop sequencer
package lvss_pkg;

   // Register offsets on the plain register port
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] DELAY_OFS  = 4'h1;
   localparam logic [3:0] CPUSET_OFS = 4'h2;
   localparam logic [3:0] STATUS_OFS = 4'h3;

   // Control register fields
   localparam int LPSLEEP_POS = 0;
   localparam int LVSLEEP_POS = 1;
   localparam int CPUOFF_POS  = 2;
   localparam int SHARED_POS  = 3;

   // Exit delay field width and recommended reset value (about 524 us)
   localparam int          DLY_W     = 22;
   localparam logic [21:0] DLY_RESET = 22'h020000;

   // Clock rate and timing figures
   localparam int CLK_MHZ          = 250;
   localparam int CORE_SETTLE_US   = 234;
   localparam int OSC_STABLE_US    = 5;
   localparam int PLAIN_EXIT_US    = 100;
   localparam int CORE_SETTLE_CYC  = CORE_SETTLE_US * CLK_MHZ;
   localparam int OSC_STABLE_CYC   = OSC_STABLE_US * CLK_MHZ;
   localparam int PLAIN_EXIT_CYC   = PLAIN_EXIT_US * CLK_MHZ;
   localparam logic [21:0] CPU_SETTLE_RESET = 22'h000100;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_RUN    = 3'b000,
      ST_STOP   = 3'b001,
      ST_CORE   = 3'b010,
      ST_CLOCK  = 3'b011,
      ST_EXIT   = 3'b100
   } lvss_state_t;

   // Register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } lvss_req_t;

endpackage : lvss_pkg

// ===== verif/lvss_chk.sv
// Port checker for the low-voltage stop sequencer
`timescale 1ns/1ns
module lvss_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic power_on_request_out,
   input wire logic runMode,
   input wire logic clockRestore,
   input wire logic expiryPulse
);
   logic [16:0] coreCnt_reg;
   logic [11:0] oscCnt_reg;
   // Bounds for the core settle time and the oscillator wait
   localparam logic [16:0] CORE_MIN = 17'(lvss_pkg::CORE_SETTLE_CYC - 4);
   localparam logic [11:0] OSC_LO   = 12'(lvss_pkg::OSC_STABLE_CYC - 2);
   localparam logic [11:0] OSC_HI   = 12'(lvss_pkg::OSC_STABLE_CYC + 2);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Cycles since the request rose (saturating) and cycles spent in clock restore
   always_ff @(posedge clk) begin
      coreCnt_reg <= (sys_rst || !power_on_request_out) ? {17{sys_rst}}
                                                        : coreCnt_reg + {16'h0, ~&coreCnt_reg};
      oscCnt_reg  <= (clockRestore && !sys_rst) ? oscCnt_reg + 12'h1 : 12'h0;
   end
   AST_RUN_MAIN: assert property (runMode |-> power_on_request_out)
      else $error("request low while in run");
   AST_DROP_LEAVES_RUN: assert property ($fell(power_on_request_out) |=> !runMode)
      else $error("request dropped while in run");
   AST_RISE_ON_WAKE: assert property ($rose(power_on_request_out)
                                      |-> !runMode && !clockRestore)
      else $error("request rose outside wake-up");
   AST_CORE_SETTLE: assert property ($rose(clockRestore) |-> coreCnt_reg >= CORE_MIN)
      else $error("clock restore before core settle time");
   AST_OSC_SPAN: assert property ($fell(clockRestore) |-> !runMode
                                  && oscCnt_reg >= OSC_LO && oscCnt_reg <= OSC_HI)
      else $error("oscillator wait has wrong length");
   AST_RUN_ENTRY: assert property ($rose(runMode)
                                   |-> !clockRestore && power_on_request_out)
      else $error("run entered during restore or with request low");
   AST_EXPIRY_AT_RUN: assert property ($rose(runMode) |-> ##[0:1] expiryPulse)
      else $error("no expiry pulse at return to run");
   AST_QUIET_RUN: assert property (runMode && $past(runMode, 2) |-> !expiryPulse)
      else $error("expiry pulse while idle in run");
   CVR_DROP: cover property ($fell(power_on_request_out));
   CVR_RESTORE: cover property ($rose(clockRestore));
   CVR_RUN: cover property ($rose(runMode));
endmodule : lvss_chk

// ===== verif/lvss_pmic_model.sv
// Regulator IC model with main and alternate states
`timescale 1ns/1ns
module lvss_pmic_model #(
   parameter int SETUP_CYC = 25000,
   parameter int RAMP_CYC  = 38000
) (
   input  wire logic clk,
   input  wire logic pmic_state_select_in,
   input  wire logic cpuOffVariant,
   output logic      cpuSupplyAboveThreshold
);
   int cnt_reg = 0;
   initial cpuSupplyAboveThreshold = 1'b1;
   // Alternate state when select is low; cpu regulator off only in the cpu-off variant
   always @(posedge clk) begin
      if (!pmic_state_select_in) begin
         cnt_reg <= 0;
         cpuSupplyAboveThreshold <= !cpuOffVariant;
      end else if (!cpuSupplyAboveThreshold) begin
         cnt_reg <= cnt_reg + 1;
         cpuSupplyAboveThreshold <= (cnt_reg >= SETUP_CYC + RAMP_CYC - 1);
      end
   end
endmodule : lvss_pmic_model

// ===== verif/tb.sv
// Self-checking bench for the low-voltage stop sequencer
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0, sys_rst = 1'b1, stopRequest = 1'b0, wakeupEvent = 1'b0;
   logic cpuOffVariant = 1'b0, rdPend = 1'b0;
   logic cpuGood, power_on_request_out, runMode, clockRestore, expiryPulse;
   lvss_pkg::lvss_req_t regReq = '0;
   logic [31:0] regRdata, lfsr = 32'h37046a6a, dly;
   logic [31:0] expQ[$];
   int          mismatches = 0, num_checks = 0, n;
   wire [2:0]   outs = {power_on_request_out, clockRestore, runMode};
   always #2 clk = ~clk;
   lvss_sequencer i_dut (.clk, .sys_rst, .regReq, .regRdata, .stopRequest, .wakeupEvent,
      .cpuSupplyAboveThreshold(cpuGood), .power_on_request_out, .runMode, .clockRestore,
      .expiryPulse);
   lvss_pmic_model i_pmic (.clk, .pmic_state_select_in(power_on_request_out), .cpuOffVariant,
      .cpuSupplyAboveThreshold(cpuGood));
   function automatic logic [31:0] nextRnd(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nextRnd
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Read data stand one cycle after the strobe: compare with the oldest note
   always @(posedge clk) begin
      if (rdPend) chk(regRdata, expQ.pop_front());
      rdPend <= regReq.rd;
   end
   task automatic bus(logic [3:0] a, logic [31:0] d, logic w, logic [31:0] e);
      if (!w) expQ.push_back(e);
      regReq <= '{a, d, w, !w};
      @(posedge clk);
      regReq.wr <= 1'b0;
      regReq.rd <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic waitFor(int k, logic v, int lim);
      n = 0;
      while (outs[k] !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : waitFor
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   // Watchdog against a hung sequence
   initial begin
      repeat (95000) @(posedge clk);
      mismatches++;
      close_out();
   end
   // Reset values, plain stop, shared-supply stop cut by reset, then cpu-off stop
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      bus(lvss_pkg::CTRL_OFS, 0, 0, 32'h0);
      bus(lvss_pkg::DELAY_OFS, 0, 0, 32'h20000);
      bus(lvss_pkg::CPUSET_OFS, 0, 0, 32'h100);
      bus(lvss_pkg::STATUS_OFS, 0, 0, 32'h10);
      lfsr = nextRnd(lfsr);
      bus(4'hf, lfsr, 1, 0);
      bus(4'hf, 0, 0, 32'h0);
      bus(lvss_pkg::CTRL_OFS, 32'h1, 1, 0);
      stopRequest <= 1'b1;
      repeat (8) @(posedge clk);
      chk(power_on_request_out, 1'b1);
      bus(lvss_pkg::STATUS_OFS, 0, 0, 32'h11);
      stopRequest <= 1'b0;
      wakeupEvent <= 1'b1;
      waitFor(1, 1'b1, 8);
      chk(n < 8, 1'b1);
      wakeupEvent <= 1'b0;
      waitFor(0, 1'b1, 26400);
      chk(n >= 26240 && n < 26300, 1'b1);
      // Shared regulator: low-voltage stop without the cpu-off variant, left by reset
      bus(lvss_pkg::CTRL_OFS, 32'hf, 1, 0);
      stopRequest <= 1'b1;
      waitFor(2, 1'b0, 8);
      chk(n < 8, 1'b1);
      bus(lvss_pkg::STATUS_OFS, 0, 0, 32'h01);
      stopRequest <= 1'b0;
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk({runMode, power_on_request_out, clockRestore, expiryPulse}, 32'hc);
      bus(lvss_pkg::CTRL_OFS, 0, 0, 32'h0);
      bus(lvss_pkg::DELAY_OFS, 0, 0, 32'h20000);
      dly = nextRnd(lfsr) & 32'h3f;
      cpuOffVariant <= 1'b1;
      bus(lvss_pkg::DELAY_OFS, dly, 1, 0);
      bus(lvss_pkg::DELAY_OFS, 0, 0, dly);
      bus(lvss_pkg::CTRL_OFS, 32'h7, 1, 0);
      stopRequest <= 1'b1;
      waitFor(2, 1'b0, 8);
      chk(n < 8, 1'b1);
      stopRequest <= 1'b0;
      wakeupEvent <= 1'b1;
      waitFor(2, 1'b1, 8);
      chk(n < 8, 1'b1);
      wakeupEvent <= 1'b0;
      waitFor(1, 1'b1, 58600);
      chk(n > 58490 && n < 58600, 1'b1);
      repeat (2000) @(posedge clk);
      chk(runMode, 1'b0);
      waitFor(0, 1'b1, 4000);
      chk(n > 2400 && n < 4000, 1'b1);
      bus(lvss_pkg::STATUS_OFS, 0, 0, 32'h70);
      close_out();
   end
endmodule : tb
bind lvss_sequencer lvss_chk i_chk (.clk, .sys_rst, .power_on_request_out, .runMode,
   .clockRestore, .expiryPulse);
